// [rtl/tcdz_if.sv]
// interface carrying one time stamp and an offset into the adder
// assumes both ends on the same clock
`timescale 1ns/1ps
interface tcdz_if;
    import tcdz_pkg::*;
    tcdz_time_t t_in;
    tcdz_ofs_t ofs;
    tcdz_time_t t_out;
    modport src(output t_in, output ofs, input t_out);
    modport add(input t_in, input ofs, output t_out);
endinterface

// [rtl/tcdz_ofs_add.sv]
// registered signed minute offset adder with date rollover
// assumes offsets within one day and valid input dates
`timescale 1ns/1ps
module tcdz_ofs_add
    import tcdz_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // sync reset
    tcdz_if.add p // time in, offset in, time out
);
`include "tcdz_params.svh"
    typedef struct packed {
        tcdz_time_t r;
    } tcdz_add_st_t;
    tcdz_add_st_t s_q, s_d;

    function automatic logic [4:0] tcdz_mdays(input logic [13:0] y, input logic [3:0] m);
        logic leap;
        leap = (y[1:0] == 2'h0) && ((y % 14'h64) != 14'h0 || (y % 14'h190) == 14'h0);
        case (m)
            4'h2: tcdz_mdays = leap ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: tcdz_mdays = 5'h1e;
            default: tcdz_mdays = 5'h1f;
        endcase
    endfunction

    // add offset, step date forward or back on rollover
    always_comb begin
        logic signed [12:0] m;
        tcdz_time_t t;
        m = 13'sh0;
        t = p.t_in;
        m = $signed({2'h0, p.t_in.mod}) + 13'(p.ofs);
        if (m < 13'sh0) begin
            t.mod = 11'(m + 13'(`TCDZ_MIN_PER_DAY));
            if (t.day == 5'h01) begin
                if (t.month == 4'h1) begin
                    t.month = 4'hc;
                    t.year = t.year - 14'h1;
                end else begin
                    t.month = t.month - 4'h1;
                end
                t.day = tcdz_mdays(t.year, t.month);
            end else begin
                t.day = t.day - 5'h01;
            end
        end else if (m >= 13'(`TCDZ_MIN_PER_DAY)) begin
            t.mod = 11'(m - 13'(`TCDZ_MIN_PER_DAY));
            if (t.day == tcdz_mdays(t.year, t.month)) begin
                t.day = 5'h01;
                if (t.month == 4'hc) begin
                    t.month = 4'h1;
                    t.year = t.year + 14'h1;
                end else begin
                    t.month = t.month + 4'h1;
                end
            end else begin
                t.day = t.day + 5'h01;
            end
        end else begin
            t.mod = 11'(m);
        end
        s_d.r = t;
    end

    // register result
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign p.t_out = s_q.r;
endmodule

// [rtl/tcdz_params.svh]
// constants for the timecode date and zone handler
// assumes inclusion by bare name from design files
`ifndef TCDZ_PARAMS_SVH
`define TCDZ_PARAMS_SVH
`define TCDZ_MODE_IGNORE 2'h0
`define TCDZ_MODE_IN 2'h1
`define TCDZ_MODE_INOUT 2'h2
`define TCDZ_SRC_INTERNAL 2'h0
`define TCDZ_SRC_VITC 2'h1
`define TCDZ_SRC_LTC 2'h2
`define TCDZ_SRC_GPS 2'h3
`define TCDZ_STABLE_FRAMES 7'h64
`define TCDZ_MIN_PER_DAY 11'h5a0
`define TCDZ_RST_YEAR 14'h07d0
`define TCDZ_RST_MONTH 4'h1
`define TCDZ_RST_DAY 5'h01
`endif

// [rtl/tcdz_pkg.sv]
// types for the timecode date and zone handler
// assumes tcdz_params.svh is compiled alongside
package tcdz_pkg;
    // signed offset in minutes, range +-23:59
    typedef logic signed [11:0] tcdz_ofs_t;
    // calendar date plus minute-of-day, seconds and frames
    typedef struct packed {
        logic [13:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [10:0] mod;
        logic [5:0] sec;
        logic [5:0] frm;
    } tcdz_time_t;
endpackage

// [rtl/tcdz_top.sv]
// time-of-day date and zone handler: master utc time and output rebuild
// assumes input timecode decoded elsewhere, frame strobe on clk, one output
`timescale 1ns/1ps
// How it works
// - ignore mode uses only hh:mm:ss:ff
// - ignore: local offsets, date from rtc
// - ignore: status shows local settings
// - input mode: master = received minus zone
// - input mode: outputs use local offsets
// - in/out mode: outputs use received offsets
// - ignore: subtract local, add back out
// - per-output shift keeps unit zone field
// - dst applies in ignore/input, any signal
// - st309 fields always in ltc/black
// - st309 fields in enabled sdi timecode
// - status reports received zone and dst
// - mode resets to ignore
// - staged internal time applied on confirm
// - power-up internal time from rtc
// - vitc only with video genlock
// - follow after 100 stable frames
module tcdz_top
    import tcdz_pkg::*;
#(
    parameter int STABLE_W = 7 // stable frame counter width
) (
    input wire logic clk, // 250 mhz system clock
    input wire logic rst, // sync reset, active high
    input wire logic [1:0] mode_sel, // st309 data mode
    input wire logic mode_load, // one-cycle strobe to take mode_sel
    input wire logic [1:0] time_of_day_source, // internal, vitc, ltc, gps
    input wire logic ref_is_genlock, // reference is a video genlock
    input wire logic frame_tick, // one pulse per input frame
    input wire logic tc_valid, // decoded timecode present this frame
    input wire tcdz_time_t tc_in, // received date and time
    input wire logic st309_present, // received st309 data present
    input wire tcdz_ofs_t rx_zone, // received zone offset, minutes
    input wire logic rx_dst, // received dst flag
    input wire tcdz_ofs_t loc_zone, // configured zone offset
    input wire tcdz_ofs_t loc_dst, // scheduled dst offset
    input wire logic loc_dst_on, // scheduler has dst active
    input wire tcdz_time_t rtc_time, // real-time clock value
    input wire tcdz_time_t staged_time, // manually staged time
    input wire logic staged_confirm, // one-cycle apply strobe
    input wire tcdz_ofs_t out_ofs, // per-output timecode offset
    input wire logic sdi_tc_en, // sdi embedded timecode enabled
    output tcdz_time_t master_utc, // master time, utc
    output tcdz_time_t out_time, // rebuilt output timecode
    output tcdz_ofs_t out_zone, // st309 zone field on outputs
    output logic out_dst, // st309 dst flag on outputs
    output logic ltc_st309_ins, // st309 fields inserted in ltc/black
    output logic sdi_st309_ins, // st309 fields inserted in sdi
    output tcdz_ofs_t stat_zone, // status zone offset
    output logic stat_dst, // status dst flag
    output logic stat_rx_valid, // status shows received st309
    output tcdz_ofs_t stat_rx_zone, // status received zone
    output logic stat_rx_dst, // status received dst
    output logic locked // input tracked after stable run
);
`include "tcdz_params.svh"
    typedef struct packed {
        logic [1:0] mode;
        logic boot;
        logic [STABLE_W-1:0] run;
        logic lock;
        tcdz_time_t utc;
        tcdz_ofs_t ozone;
        logic odst;
        tcdz_ofs_t szone;
        logic sdst;
        logic rxv;
        tcdz_ofs_t rxz;
        logic rxd;
        logic ltc_ins;
        logic sdi_ins;
    } tcdz_st_t;
    tcdz_st_t s_q, s_d;

    tcdz_if in_if ();
    tcdz_if out_if ();
    tcdz_ofs_t loc_tot;
    tcdz_ofs_t rx_tot;
    logic tc_src;
    logic use_rx;

    tcdz_ofs_add u_in (
        .clk(clk),
        .rst(rst),
        .p(in_if.add)
    );
    tcdz_ofs_add u_out (
        .clk(clk),
        .rst(rst),
        .p(out_if.add)
    );

    // offset sums are not saturated: zone, dst and per-output shift
    // together must stay within one day of minutes
    // offsets: local zone plus scheduled dst, received zone
    assign loc_tot = loc_zone + (loc_dst_on ? loc_dst : 12'sh0);
    assign rx_tot = rx_zone;
    // vitc needs genlock, ltc always usable
    assign tc_src = (time_of_day_source == `TCDZ_SRC_LTC) ||
                    (time_of_day_source == `TCDZ_SRC_VITC && ref_is_genlock);
    assign use_rx = (s_q.mode != `TCDZ_MODE_IGNORE) && st309_present;

    // input path: subtract offset to reach utc
    // the received zone counts only while st309 data is present
    always_comb begin
        in_if.t_in = tc_in;
        in_if.ofs = -loc_tot;
        if (s_q.mode == `TCDZ_MODE_IGNORE) begin
            in_if.t_in.year = rtc_time.year;
            in_if.t_in.month = rtc_time.month;
            in_if.t_in.day = rtc_time.day;
        end else if (st309_present) begin
            in_if.ofs = -rx_tot;
        end
    end

    // output path: add output zone and per-output shift
    // without st309 data the local offsets stand in
    always_comb begin
        out_if.t_in = s_q.utc;
        if (s_q.mode == `TCDZ_MODE_INOUT && st309_present) begin
            out_if.ofs = rx_tot + out_ofs;
        end else begin
            out_if.ofs = loc_tot + out_ofs;
        end
    end

    // next state
    always_comb begin
        s_d = s_q;
        if (mode_load) begin
            s_d.mode = (mode_sel == 2'h3) ? `TCDZ_MODE_IGNORE : mode_sel;
        end

        // stable-run counter over consecutive valid frames
        // an unusable source loses the lock at once
        if (!tc_src) begin
            s_d.run = '0;
            s_d.lock = 1'b0;
        end else if (frame_tick) begin
            if (!tc_valid) begin
                s_d.run = '0;
                s_d.lock = 1'b0;
            end else if (s_q.run >= STABLE_W'(`TCDZ_STABLE_FRAMES - 7'h1)) begin
                s_d.lock = 1'b1;
            end else begin
                s_d.run = s_q.run + STABLE_W'(1);
            end
        end

        // master time sources
        // the boot load wins over a confirm in the same cycle
        if (s_q.boot) begin
            s_d.utc = rtc_time;
            s_d.boot = 1'b0;
        end else if (time_of_day_source == `TCDZ_SRC_INTERNAL && staged_confirm) begin
            s_d.utc = staged_time;
        end else if (tc_src && s_q.lock) begin
            s_d.utc = in_if.t_out;
        end

        // st309 output fields follow the mode
        // a per-output shift never reaches the zone field
        if (use_rx && s_q.mode == `TCDZ_MODE_INOUT) begin
            s_d.ozone = rx_zone;
            s_d.odst = rx_dst;
        end else begin
            s_d.ozone = loc_zone;
            s_d.odst = loc_dst_on;
        end
        s_d.ltc_ins = 1'b1;
        s_d.sdi_ins = sdi_tc_en;

        // status readout
        if (use_rx) begin
            s_d.szone = rx_zone;
            s_d.sdst = rx_dst;
        end else begin
            s_d.szone = loc_zone;
            s_d.sdst = loc_dst_on;
        end
        s_d.rxv = st309_present;
        if (st309_present) begin
            s_d.rxz = rx_zone;
            s_d.rxd = rx_dst;
        end
    end

    // state register
    // calendar fields reset to a legal date for the adders
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.mode <= `TCDZ_MODE_IGNORE;
            s_q.boot <= 1'b1;
            s_q.utc.year <= `TCDZ_RST_YEAR;
            s_q.utc.month <= `TCDZ_RST_MONTH;
            s_q.utc.day <= `TCDZ_RST_DAY;
        end else begin
            s_q <= s_d;
        end
    end

    // every output comes straight from a flip-flop
    assign master_utc = s_q.utc;
    assign out_time = out_if.t_out;
    assign out_zone = s_q.ozone;
    assign out_dst = s_q.odst;
    assign ltc_st309_ins = s_q.ltc_ins;
    assign sdi_st309_ins = s_q.sdi_ins;
    assign stat_zone = s_q.szone;
    assign stat_dst = s_q.sdst;
    assign stat_rx_valid = s_q.rxv;
    assign stat_rx_zone = s_q.rxz;
    assign stat_rx_dst = s_q.rxd;
    assign locked = s_q.lock;
endmodule

// [tb/tcdz_props.sv]
// concurrent checks on the handler top ports
// assumes tcdz_top port names and tcdz_params.svh constants
`timescale 1ns/1ps
`include "tcdz_params.svh"
module tcdz_props
    import tcdz_pkg::*;
(
    input logic clk, // clock
    input logic rst, // sync reset
    input logic [1:0] time_of_day_source, // source
    input logic ref_is_genlock, // genlock ref
    input logic frame_tick, // frame strobe
    input logic tc_valid, // tc valid
    input logic st309_present, // st309 seen
    input tcdz_ofs_t rx_zone, // rx zone
    input tcdz_time_t rtc_time, // rtc
    input tcdz_time_t staged_time, // staged
    input logic staged_confirm, // apply
    input logic sdi_tc_en, // sdi enable
    input tcdz_time_t master_utc, // master
    input logic ltc_st309_ins, // ltc ins
    input logic sdi_st309_ins, // sdi ins
    input logic stat_rx_valid, // rx valid
    input tcdz_ofs_t stat_rx_zone, // rx zone
    input logic locked // lock
);
    logic [7:0] run_q;
    logic [7:0] run_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // consecutive valid frame count, saturating
    always_comb begin
        run_d = run_q;
        if (frame_tick) run_d = !tc_valid ? 8'h00 : (run_q == 8'hff ? run_q : run_q + 8'h01);
    end
    always_ff @(posedge clk) run_q <= rst ? 8'h00 : run_d;
    AST_BOOT_RTC: assert property ($fell(rst) |=> master_utc == $past(rtc_time))
        else $error("boot time not from rtc");
    AST_CONFIRM: assert property (!$past(rst) && staged_confirm &&
        time_of_day_source == `TCDZ_SRC_INTERNAL |=> master_utc == $past(staged_time))
        else $error("staged time not applied");
    AST_LTC_INS: assert property (!$past(rst) |-> ltc_st309_ins)
        else $error("ltc st309 fields missing");
    AST_SDI_INS: assert property (sdi_tc_en != sdi_st309_ins |=> sdi_st309_ins == $past(sdi_tc_en))
        else $error("sdi st309 insert wrong");
    AST_RX_STAT: assert property (st309_present |=> stat_rx_valid && stat_rx_zone == $past(rx_zone))
        else $error("rx status wrong");
    AST_VITC_GEN: assert property ((time_of_day_source == `TCDZ_SRC_VITC && !ref_is_genlock)[*2]
        |-> !locked) else $error("vitc locked without genlock");
    AST_LOCK_CLR: assert property (frame_tick && !tc_valid |=> !locked)
        else $error("lock kept on bad frame");
    AST_LOCK_RUN: assert property ($rose(locked) |-> run_q >= 8'h64)
        else $error("lock before stable run");
endmodule
bind tcdz_top tcdz_props u_props (.clk(clk), .rst(rst), .time_of_day_source(time_of_day_source),
    .ref_is_genlock(ref_is_genlock), .frame_tick(frame_tick), .tc_valid(tc_valid),
    .st309_present(st309_present), .rx_zone(rx_zone), .rtc_time(rtc_time),
    .staged_time(staged_time), .staged_confirm(staged_confirm), .sdi_tc_en(sdi_tc_en),
    .master_utc(master_utc), .ltc_st309_ins(ltc_st309_ins), .sdi_st309_ins(sdi_st309_ins),
    .stat_rx_valid(stat_rx_valid), .stat_rx_zone(stat_rx_zone), .locked(locked));

// [tb/tcdz_tc_src.sv]
// timecode source model: decoded ltc/vitc fields, one frame per four clocks
// assumes bench sets content; lines scramble while the source is absent
`timescale 1ns/1ps
module tcdz_tc_src
    import tcdz_pkg::*;
(
    input logic clk, // clock
    input logic en, // source present
    input tcdz_time_t t, // time sent
    input tcdz_ofs_t zone, // zone sent
    input logic dst, // dst sent
    input logic has309, // st309 carried
    input logic drop, // frame sent without valid timecode
    output logic frame_tick, // frame strobe
    output logic tc_valid, // tc valid
    output tcdz_time_t tc_in, // decoded time
    output logic st309_present, // st309 present
    output tcdz_ofs_t rx_zone, // decoded zone
    output logic rx_dst // decoded dst
);
    logic [1:0] div_q = 2'h0;
    // known values at time zero
    initial begin
        frame_tick = 0; tc_valid = 0; tc_in = '0; st309_present = 0; rx_zone = '0; rx_dst = 0;
    end
    // drive just after each edge; released lines toggle rather than hold
    always @(posedge clk) begin
        #1;
        div_q = div_q + 2'h1;
        frame_tick = en && div_q == 2'h0;
        tc_valid = en && !drop;
        st309_present = en && has309;
        tc_in = en ? t : ~tc_in;
        rx_zone = en ? zone : ~rx_zone;
        rx_dst = en ? dst : ~rx_dst;
    end
endmodule

// [tb/tcdz_top_tb_top.sv]
// self-checking bench for the timecode date and zone handler
// assumes tcdz_top, tcdz_tc_src and tcdz_props compiled alongside
`timescale 1ns/1ps
`include "tcdz_params.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t got %h exp %h", $time, a, e); end end
module tcdz_top_tb_top;
    import tcdz_pkg::*;
    logic clk, rst, mode_load, ref_is_genlock, loc_dst_on, staged_confirm, sdi_tc_en, en, dst;
    logic frame_tick, tc_valid, st309_present, rx_dst, out_dst, ltc_st309_ins, sdi_st309_ins;
    logic stat_dst, stat_rx_valid, stat_rx_dst, locked, drop, h309, rxm, iom, rxd_m;
    tcdz_ofs_t rxz_m;
    logic [1:0] mode_sel, time_of_day_source;
    tcdz_time_t tc_in, rtc_time, staged_time, t, em, eo, master_utc, out_time;
    tcdz_ofs_t rx_zone, loc_zone, loc_dst, out_ofs, zone, out_zone, stat_zone, stat_rx_zone;
    int n_mismatch = 0, check_count = 0, seed = 32'h12f7, lt, r;
    tcdz_top DUT (.clk(clk), .rst(rst), .mode_sel(mode_sel), .mode_load(mode_load),
        .time_of_day_source(time_of_day_source), .ref_is_genlock(ref_is_genlock),
        .frame_tick(frame_tick), .tc_valid(tc_valid), .tc_in(tc_in), .st309_present(st309_present),
        .rx_zone(rx_zone), .rx_dst(rx_dst), .loc_zone(loc_zone), .loc_dst(loc_dst),
        .loc_dst_on(loc_dst_on), .rtc_time(rtc_time), .staged_time(staged_time),
        .staged_confirm(staged_confirm), .out_ofs(out_ofs), .sdi_tc_en(sdi_tc_en),
        .master_utc(master_utc), .out_time(out_time), .out_zone(out_zone), .out_dst(out_dst),
        .ltc_st309_ins(ltc_st309_ins), .sdi_st309_ins(sdi_st309_ins), .stat_zone(stat_zone),
        .stat_dst(stat_dst), .stat_rx_valid(stat_rx_valid), .stat_rx_zone(stat_rx_zone),
        .stat_rx_dst(stat_rx_dst), .locked(locked));
    tcdz_tc_src u_src (.clk(clk), .en(en), .t(t), .zone(zone), .dst(dst), .has309(h309),
        .drop(drop), .frame_tick(frame_tick), .tc_valid(tc_valid), .tc_in(tc_in),
        .st309_present(st309_present), .rx_zone(rx_zone), .rx_dst(rx_dst));
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tick_n(input int n);
        repeat (n) @(posedge clk iff frame_tick);
    endtask
    // random time and offsets kept clear of a day rollover
    task automatic rnd_env();
        r = $random(seed);
        t = '{14'(2000 + (r & 63)), 4'((r >> 6 & 7) + 1), 5'((r >> 9 & 15) + 1),
            11'(300 + (r >> 13 & 511)), 6'(r >> 22 & 31), 6'(r >> 27 & 15)};
        r = $random(seed);
        zone = 12'(r % 61);
        loc_zone = 12'((r >> 8) % 61);
        loc_dst = 12'((r >> 16) % 61);
        out_ofs = 12'((r >> 3) % 61);
        {dst, loc_dst_on, sdi_tc_en} = r[26:24];
    endtask
    // reference model of master and rebuilt output for mode m
    task automatic exp_calc(input int m);
        rxm = (m == 1 || m == 2) && h309;
        iom = (m == 2) && h309;
        lt = int'(loc_zone) + (loc_dst_on ? int'(loc_dst) : 0);
        em = t;
        if (rxm) em.mod = 11'(int'(t.mod) - int'(zone));
        else em.mod = 11'(int'(t.mod) - lt);
        if (m == 0 || m == 3) begin
            {em.year, em.month, em.day} = {rtc_time.year, rtc_time.month, rtc_time.day};
        end
        if (h309) begin
            rxz_m = zone;
            rxd_m = dst;
        end
        eo = em;
        eo.mod = 11'(int'(em.mod) + (iom ? int'(zone) : lt) + int'(out_ofs));
    endtask
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        n_mismatch++;
        test_done();
    end
    // main sequence
    initial begin
        rst = 1; mode_sel = 0; mode_load = 0; ref_is_genlock = 1; en = 0; staged_confirm = 0;
        drop = 0; h309 = 1;
        time_of_day_source = `TCDZ_SRC_LTC;
        rtc_time = '{14'h07e5, 4'h6, 5'h0f, 11'h258, 6'h1e, 6'h05};
        staged_time = rtc_time;
        rnd_env();
        repeat (12) @(posedge clk);
        #1 rst = 0;
        step(1);
        `CHK(master_utc, rtc_time)
        `CHK(stat_zone, loc_zone)
        `CHK(stat_dst, loc_dst_on)
        en = 1;
        tick_n(99);
        step(1);
        `CHK(locked, 1'b0)
        tick_n(1);
        step(1);
        `CHK(locked, 1'b1)
        drop = 1;
        tick_n(1);
        step(1);
        `CHK(locked, 1'b0)
        drop = 0;
        tick_n(100);
        step(1);
        `CHK(locked, 1'b1)
        for (int m = 0; m < 8; m++) begin
            rnd_env();
            h309 = (m < 4);
            mode_sel = 2'(m);
            mode_load = 1;
            step(1);
            mode_load = 0;
            step(6);
            exp_calc(m % 4);
            `CHK(master_utc, em)
            `CHK(out_time, eo)
            `CHK(out_zone, iom ? zone : loc_zone)
            `CHK(out_dst, iom ? dst : loc_dst_on)
            `CHK(stat_rx_zone, rxz_m)
            `CHK(stat_rx_dst, rxd_m)
            `CHK(stat_rx_valid, h309)
            `CHK(stat_zone, rxm ? zone : loc_zone)
            `CHK(stat_dst, rxm ? dst : loc_dst_on)
            `CHK(ltc_st309_ins, 1'b1)
            `CHK(sdi_st309_ins, sdi_tc_en)
        end
        staged_confirm = 1;
        step(1);
        staged_confirm = 0;
        step(1);
        `CHK(master_utc, em)
        time_of_day_source = `TCDZ_SRC_INTERNAL;
        staged_time.mod = 11'h3c0;
        staged_confirm = 1;
        step(1);
        staged_confirm = 0;
        `CHK(master_utc, staged_time)
        // mid-run reset: manual time is not kept and the mode returns to ignore
        h309 = 1;
        mode_sel = 2'h1;
        mode_load = 1;
        step(1);
        mode_load = 0;
        rst = 1;
        step(2);
        rst = 0;
        step(1);
        `CHK(master_utc, rtc_time)
        `CHK(stat_zone, loc_zone)
        time_of_day_source = `TCDZ_SRC_VITC;
        ref_is_genlock = 0;
        tick_n(110);
        step(1);
        `CHK(locked, 1'b0)
        ref_is_genlock = 1;
        tick_n(100);
        step(1);
        `CHK(locked, 1'b1)
        test_done();
    end
endmodule
